// ### hdl/iob_dec_if.sv
// Interface carrying decoded operation fields between decoder and top.
// Assumes a single clock domain.
`timescale 1ns/10ps
`default_nettype none
interface iob_dec_if;
	logic                       is_bset;
	logic                       is_fill;
	logic [iob_pkg::ADDR_W-1:0] addr;
	logic [2:0]                 bit_pos;
	modport dec (output is_bset, output is_fill, output addr, output bit_pos);
	modport use_side (input is_bset, input is_fill, input addr, input bit_pos);
endinterface : iob_dec_if
`default_nettype wire

// ### hdl/iob_decode.sv
// Combinational decoder for the two indexed instructions.
// Assumes opcode and pointer are stable while issue is high.
`timescale 1ns/10ps
`default_nettype none
module iob_decode (
	input  wire logic [iob_pkg::OP_W-1:0]   opcode_in,
	input  wire logic [iob_pkg::ADDR_W-1:0] second_file_select_pointer_in,
	input  wire logic                       extended_instr_config_bit_in,
	iob_dec_if.dec                          dec
);
	wire logic [7:0] k_w;
	wire logic       idx_ok_w;
	wire logic       access_w;
	assign k_w      = opcode_in[iob_pkg::K_HI:iob_pkg::K_LO];
	assign access_w = ~opcode_in[iob_pkg::A_BIT];
	// Offset 0..95 only, and only with the extension on
	assign idx_ok_w = extended_instr_config_bit_in & access_w & (k_w <= iob_pkg::K_MAX);
	assign dec.is_bset = idx_ok_w
		& (opcode_in[iob_pkg::TOP_HI:iob_pkg::BS_LO] == iob_pkg::BSET_TOP);
	assign dec.is_fill = idx_ok_w
		& (opcode_in[iob_pkg::TOP_HI:iob_pkg::FL_LO] == iob_pkg::FILL_TOP);
	// Pointer plus literal offset
	assign dec.addr    = second_file_select_pointer_in
		+ {{(iob_pkg::ADDR_W-8){1'b0}}, k_w};
	assign dec.bit_pos = opcode_in[iob_pkg::B_HI:iob_pkg::B_LO];
endmodule : iob_decode
`default_nettype wire

// ### hdl/iob_exec.sv
// Execute path for indexed bit-set and fill-with-ones instructions.
// Assumes the core holds issue for one clock and waits for done_out.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Bit-set indexed takes offset 0..95 and bit 0..7 from the opcode
// - Fill indexed address is second pointer value plus literal offset
// - Fill indexed writes FFh to the computed address
// - With the extension bit clear, no indexed operation is performed
module iob_exec (
	input  wire logic                       clk_in,
	input  wire logic                       srst_in,
	input  wire logic                       issue_in,
	input  wire logic [iob_pkg::OP_W-1:0]   opcode_in,
	input  wire logic [iob_pkg::ADDR_W-1:0] second_file_select_pointer_in,
	input  wire logic                       extended_instr_config_bit_in,
	input  wire logic [iob_pkg::DATA_W-1:0] rd_data_in,
	output logic      [iob_pkg::ADDR_W-1:0] mem_addr_out,
	output logic                            rd_en_out,
	output logic                            wr_en_out,
	output logic      [iob_pkg::DATA_W-1:0] wr_data_out,
	output logic                            done_out,
	output logic                            handled_out
);
	// ========================================
	// Decode
	iob_dec_if dec_if ();
	iob_decode u_dec (
		.opcode_in                     (opcode_in),
		.second_file_select_pointer_in (second_file_select_pointer_in),
		.extended_instr_config_bit_in  (extended_instr_config_bit_in),
		.dec                           (dec_if.dec)
	);
	// ========================================
	// Registers and next values
	iob_pkg::iob_state_t          state_q;
	iob_pkg::iob_state_t          state_d;
	logic [2:0]                   bit_q;
	wire logic [2:0]              bit_d;
	logic [iob_pkg::ADDR_W-1:0]   addr_q;
	wire logic [iob_pkg::ADDR_W-1:0] addr_d;
	logic                         rd_en_q;
	wire logic                    rd_en_d;
	logic                         wr_en_q;
	wire logic                    wr_en_d;
	logic [iob_pkg::DATA_W-1:0]   wr_data_q;
	wire logic [iob_pkg::DATA_W-1:0] wr_data_d;
	logic                         done_q;
	wire logic                    done_d;
	logic                         handled_q;
	wire logic                    handled_d;
	// ========================================
	// State qualifiers
	wire logic                    in_idle_w;
	wire logic                    in_read_w;
	wire logic                    in_write_w;
	assign in_idle_w  = (state_q == iob_pkg::ST_IDLE);
	assign in_read_w  = (state_q == iob_pkg::ST_READ);
	assign in_write_w = (state_q == iob_pkg::ST_WRITE);
	// ========================================
	// Issue acceptance
	wire logic                    take_w;
	wire logic                    take_fill_w;
	wire logic                    take_bset_w;
	wire logic                    take_other_w;
	wire logic                    ours_w;
	// Issue while busy is ignored
	assign take_w       = in_idle_w & issue_in;
	assign ours_w       = dec_if.is_bset | dec_if.is_fill;
	assign take_fill_w  = take_w & dec_if.is_fill;
	assign take_bset_w  = take_w & dec_if.is_bset & ~dec_if.is_fill;
	assign take_other_w = take_w & ~ours_w;
	// ========================================
	// Bit merge
	wire logic [iob_pkg::DATA_W-1:0] mask_w;
	wire logic [iob_pkg::DATA_W-1:0] merged_w;
	// Only the chosen bit is forced, the rest pass through
	assign mask_w   = iob_pkg::ONE_BIT << bit_q;
	assign merged_w = rd_data_in | mask_w;
	// ========================================
	// Next values
	assign addr_d    = take_w ? dec_if.addr : addr_q;
	assign bit_d     = take_w ? dec_if.bit_pos : bit_q;
	assign handled_d = take_w ? ours_w : handled_q;
	assign rd_en_d   = take_bset_w;
	assign wr_en_d   = take_fill_w | in_read_w;
	assign wr_data_d = take_fill_w ? iob_pkg::ALL_ONES :
		(in_read_w ? merged_w : wr_data_q);
	// One done pulse per accepted issue
	assign done_d    = take_other_w | in_write_w;
	// ========================================
	// Sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			iob_pkg::ST_IDLE: begin
				if (take_fill_w) begin
					state_d = iob_pkg::ST_WRITE;
				end else if (take_bset_w) begin
					state_d = iob_pkg::ST_READ;
				end
			end
			iob_pkg::ST_READ: begin
				state_d = iob_pkg::ST_WRITE;
			end
			iob_pkg::ST_WRITE: begin
				state_d = iob_pkg::ST_IDLE;
			end
			default: begin
				state_d = iob_pkg::ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= iob_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end
	// ========================================
	// Captured operands
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			bit_q <= '0;
		end else begin
			bit_q <= bit_d;
		end
	end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			addr_q <= '0;
		end else begin
			addr_q <= addr_d;
		end
	end
	// ========================================
	// Memory strobes
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rd_en_q <= 1'b0;
		end else begin
			rd_en_q <= rd_en_d;
		end
	end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wr_en_q <= 1'b0;
		end else begin
			wr_en_q <= wr_en_d;
		end
	end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wr_data_q <= '0;
		end else begin
			wr_data_q <= wr_data_d;
		end
	end
	// ========================================
	// Completion
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			done_q <= 1'b0;
		end else begin
			done_q <= done_d;
		end
	end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			handled_q <= 1'b0;
		end else begin
			handled_q <= handled_d;
		end
	end
	// ========================================
	// Outputs
	assign mem_addr_out = addr_q;
	assign rd_en_out    = rd_en_q;
	assign wr_en_out    = wr_en_q;
	assign wr_data_out  = wr_data_q;
	assign done_out     = done_q;
	assign handled_out  = handled_q;
endmodule : iob_exec
`default_nettype wire

// ### hdl/iob_pkg.sv
// Constants for the indexed bit-set and fill execute block.
// Assumes a byte-wide data memory with a 12-bit address.
package iob_pkg;
	// ========================================
	// Widths
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned OP_W   = 16;
	// ========================================
	// Opcode fields
	localparam int unsigned K_LO   = 0;
	localparam int unsigned K_HI   = 7;
	localparam int unsigned B_LO   = 9;
	localparam int unsigned B_HI   = 11;
	localparam int unsigned A_BIT  = 8;
	localparam int unsigned TOP_HI = 15;
	localparam int unsigned BS_LO  = 12;
	localparam int unsigned FL_LO  = 8;
	// ========================================
	// Opcode patterns
	localparam logic [3:0] BSET_TOP = 4'h8;
	localparam logic [7:0] FILL_TOP = 8'h68;
	// Offsets at or below this value are indexed
	localparam logic [7:0] K_MAX    = 8'h5f;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] ONE_BIT  = 8'h01;
	// ========================================
	// Execute states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE
	} iob_state_t;
endpackage : iob_pkg

// ### test/iob_exec_asserts.sv
// Checker for the indexed bit-set and fill block.
// Bound to iob_exec; issue comes only while idle.
`timescale 1ns/10ps
`default_nettype none
module iob_exec_asserts (
	input wire logic        clk_in,
	input wire logic        srst_in,
	input wire logic        issue_in,
	input wire logic [15:0] opcode_in,
	input wire logic [11:0] second_file_select_pointer_in,
	input wire logic        extended_instr_config_bit_in,
	input wire logic [7:0]  rd_data_in,
	input wire logic [11:0] mem_addr_out,
	input wire logic        rd_en_out,
	input wire logic        wr_en_out,
	input wire logic [7:0]  wr_data_out,
	input wire logic        done_out,
	input wire logic        handled_out
);
	wire ok = issue_in && extended_instr_config_bit_in && opcode_in[7:0] < 8'h60 && !opcode_in[8];
	wire fl = ok && opcode_in[15:8] == 8'h68;
	wire bs = ok && opcode_in[15:12] == 4'h8 && !opcode_in[8];
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (srst_in);
	fill_write_a: assert property (fl |=> wr_en_out && wr_data_out == 8'hff &&
		mem_addr_out == $past(second_file_select_pointer_in) + $past(opcode_in[7:0]))
		else $error("bad fill");
	bset_write_a: assert property (bs |=> rd_en_out ##1 wr_en_out &&
		wr_data_out == (rd_data_in | 8'h01 << $past(opcode_in[11:9], 2))) else $error("bad bit");
	bset_done_a: assert property (bs |-> ##3 done_out && handled_out)
		else $error("bad bit done");
	ext_off_a: assert property (issue_in && !extended_instr_config_bit_in |=> done_out &&
		!handled_out &&
		!rd_en_out && !wr_en_out) else $error("op ran while off");
	range_skip_a: assert property (issue_in && opcode_in[7:0] > 8'h5f |=> !wr_en_out &&
		!handled_out && done_out) else $error("offset over range ran");
	cover property (fl);
	cover property (bs);
	cover property (issue_in && !extended_instr_config_bit_in);
endmodule : iob_exec_asserts
`default_nettype wire

// ### test/iob_exec_tb_top.sv
// Self-checking bench for the indexed bit-set and fill block.
// Bench answers memory reads with a held random byte.
`timescale 1ns/10ps
`default_nettype none
module iob_exec_tb_top;
	logic        clk_in = 1'h0, srst_in = 1'h1, issue_in = 1'h0;
	logic        extended_instr_config_bit_in = 1'h0;
	logic [15:0] opcode_in = 16'h0, op;
	logic [11:0] second_file_select_pointer_in = 12'h0, mem_addr_out;
	logic [7:0]  rd_data_in = 8'h0, wr_data_out;
	logic        rd_en_out, wr_en_out, done_out, handled_out;
	int          fail_count = 0, checked = 0, exp_q[$];
	iob_exec i_dut (.clk_in, .srst_in, .issue_in, .opcode_in, .second_file_select_pointer_in,
		.extended_instr_config_bit_in,
		.rd_data_in, .mem_addr_out, .rd_en_out, .wr_en_out, .wr_data_out, .done_out, .handled_out);
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic run(input logic [15:0] o, input logic x);
		logic [7:0]  r = 8'($urandom);
		logic [11:0] f = 12'($urandom);
		logic        hit = x && o[7:0] < 8'h60 && !o[8] && (o[15:8] == 8'h68 || o[15:12] == 4'h8);
		if (hit) exp_q.push_back({f + o[7:0], o[15] ? r | 8'h01 << o[11:9] : 8'hff});
		@(posedge clk_in);
		{issue_in, opcode_in, second_file_select_pointer_in, extended_instr_config_bit_in,
			rd_data_in} <= {1'h1, o, f, x, r};
		@(posedge clk_in) issue_in <= 1'h0;
		for (int n = 0; n < 8; n++) begin
			@(negedge clk_in);
			if (wr_en_out) chk({mem_addr_out, wr_data_out}, exp_q.pop_front());
			if (done_out) break;
		end
		chk({done_out, handled_out, 8'(exp_q.size())}, {1'h1, hit, 8'h0});
	endtask : run
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	initial forever #2.5 clk_in = ~clk_in;
	initial begin
		#10000;
		fail_count++;
		give_verdict();
	end
	initial begin
		void'($urandom(48));
		repeat (20) @(posedge clk_in);
		srst_in <= 1'h0;
		for (int i = 0; i < 60; i++) begin
			op = {i[0] ? {4'h8, 4'($urandom)} : 8'h68, i < 3 ? 8'h5e + 8'(i) : 8'($urandom)};
			run(i % 5 == 4 ? 16'($urandom) : op, i % 7 != 3);
		end
		give_verdict();
	end
endmodule : iob_exec_tb_top
bind iob_exec iob_exec_asserts u_chk (.clk_in, .srst_in, .issue_in, .opcode_in,
	.second_file_select_pointer_in, .extended_instr_config_bit_in, .rd_data_in,
	.mem_addr_out, .rd_en_out, .wr_en_out, .wr_data_out, .done_out,
	.handled_out);
`default_nettype wire
